/* iel_debounce.sv */
`timescale 1ns/1ns
module iel_debounce import iel_pkg::*; #(
  parameter int TICKS = DEBOUNCE_TICKS
) (
  input wire logic ref_clk,
  input wire logic rstSyncN,
  input wire logic tick,
  input wire logic level,
  output logic stableQ
);

  initial begin
    if (TICKS < 1 || TICKS >= 2 ** TIMER_W)
      $error("iel_debounce: bad tick count");
  end

  logic [TIMER_W-1:0] cnt_q;

  // ==========================================================
  // Level must hold for TICKS ticks before it is accepted
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cnt_q <= '0;
      stableQ <= PIN_IDLE_LEVEL;
    end else if (level == stableQ) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == TIMER_W'(TICKS - 1)) begin
        stableQ <= level;
        cnt_q <= '0;
      end
    end
  end

endmodule // iel_debounce

/* iel_flash_gen.sv */
`timescale 1ns/1ns
module iel_flash_gen import iel_pkg::*; #(
  parameter int ON_TICKS = FLASH_ON_TICKS,
  parameter int OFF_TICKS = FLASH_OFF_TICKS,
  parameter int PAUSE_TICKS = FLASH_PAUSE_TICKS
) (
  input wire logic ref_clk,
  input wire logic rstSyncN,
  input wire logic tick,
  input wire logic [1:0] flashCount,
  input wire logic steadyOn,
  output logic lampQ
);

  initial begin
    if (ON_TICKS < 1 || OFF_TICKS < 1 || PAUSE_TICKS <= OFF_TICKS || PAUSE_TICKS >= 2 ** TIMER_W)
      $error("iel_flash_gen: bad tick counts");
  end

  iel_flash_e state_q;
  logic [TIMER_W-1:0] cnt_q;
  logic [1:0] left_q;

  // ==========================================================
  // Flash groups with a long dark pause between them
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_q <= FG_IDLE;
      cnt_q <= '0;
      left_q <= FLASH_NONE;
      lampQ <= 1'b0;
    end else if (flashCount == FLASH_NONE || steadyOn) begin
      state_q <= FG_IDLE;
      cnt_q <= '0;
      lampQ <= steadyOn;
    end else begin
      unique case (state_q)
        FG_IDLE: begin
          // Count is sampled per group so a change to another nonzero count never cuts a group short
          state_q <= FG_ON;
          left_q <= flashCount - 2'h1;
          cnt_q <= '0;
          lampQ <= 1'b1;
        end
        FG_ON: begin
          if (tick) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == TIMER_W'(ON_TICKS - 1)) begin
              state_q <= FG_GAP;
              cnt_q <= '0;
              lampQ <= 1'b0;
            end
          end
        end
        FG_GAP: begin
          if (tick) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == TIMER_W'(OFF_TICKS - 1)) begin
              cnt_q <= '0;
              if (left_q == FLASH_NONE) begin
                state_q <= FG_PAUSE;
              end else begin
                state_q <= FG_ON;
                left_q <= left_q - 2'h1;
                lampQ <= 1'b1;
              end
            end
          end
        end
        FG_PAUSE: begin
          if (tick) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == TIMER_W'(PAUSE_TICKS - OFF_TICKS - 1)) begin
              state_q <= FG_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule // iel_flash_gen

/* iel_indicator_enable.sv */
`timescale 1ns/1ns
// Behaviour
// [RQ1] Fault lamp dark, else one/two/three flashes
// [RQ2] Regulation lamp off when not enabled
// [RQ3] Regulation lamp steady when within band
// [RQ4] One flash when enabled and too cold
// [RQ5] Two flashes when enabled and too hot
// [RQ6] Heartbeat lamp blinks after boot completes
// [RQ7] Boot lamp test red, yellow, green
// [RQ8] Lockout blinks three lamps in unison
// [RQ9] Lockout left only by power-on reset
// [RQ10] Rx and tx lamps flash on activity
// [RQ11] Session blinks both activity lamps periodically
// [RQ12] Run input active low, open means idle; with runPolarityHigh set the code takes it active high, so an open pin runs
// [RQ13] Active run input starts regulation and stage
// [RQ14] Software source: hardware AND software start
// [RQ15] Hardware source: hardware input alone
// [RQ16] Overcurrent cuts stage in hardware, reports fault
// [RQ17] Fault clear input clears latched faults
// [RQ18] Healthy only in normal run, no faults
// [RQ19] Flash groups repeat with dark pause
// [RQ20] Run input synchronised and debounced
// [RQ21] Highest priority fault shown, sensor first
module iel_indicator_enable import iel_pkg::*; #(
  parameter int TICK_CLKS = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic runRequestPin,
  input wire logic runPolarityHigh,
  input wire logic permitFromSoftware,
  input wire logic softwareStart,
  input wire logic faultClearInputPin,
  input wire logic faultClearPolarityHigh,
  input wire logic overcurrentPin,
  input wire iel_fault_s faultEvents,
  input wire logic tempBelowBand,
  input wire logic tempAboveBand,
  input wire logic lockoutRequest,
  input wire logic rxActivity,
  input wire logic txActivity,
  input wire logic pcSession,
  output iel_lamp_s lampsQ,
  output iel_fault_s faultsQ,
  output logic runPermitQ,
  output logic powerStageEnableQ,
  output logic regulationStatusQ,
  output logic healthyOutputQ
);

  initial begin
    if (TICK_CLKS < 1)
      $error("iel_indicator_enable: tick period too short");
  end

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rstPipe_q;
  logic rstSyncN;
  logic [1:0] runSync_q;
  logic [1:0] clrSync_q;
  logic [1:0] ocSync_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_q[1];

  // Run and fault clear pins idle high through their pull-ups; overcurrent pin idles low
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      runSync_q <= {2{PIN_IDLE_LEVEL}}; // RQ12
      clrSync_q <= {2{PIN_IDLE_LEVEL}};
      ocSync_q <= 2'h0;
    end else begin
      runSync_q <= {runSync_q[0], runRequestPin}; // RQ20
      clrSync_q <= {clrSync_q[0], faultClearInputPin};
      ocSync_q <= {ocSync_q[0], overcurrentPin};
    end
  end

  // ==========================================================
  // Base tick and blink phase
  logic [31:0] div_q;
  logic tick;
  logic [TIMER_W-1:0] beat_q;
  logic blink_q;
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      div_q <= '0;
    end else if (div_q == 32'(TICK_CLKS - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end
  assign tick = (div_q == 32'(TICK_CLKS - 1));

  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      beat_q <= '0;
      blink_q <= 1'b0;
    end else if (tick) begin
      if (beat_q == TIMER_W'(HEARTBEAT_TICKS - 1)) begin
        beat_q <= '0;
        blink_q <= ~blink_q;
      end else begin
        beat_q <= beat_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Run permit
  logic runLevel;
  logic hwRunActive;
  logic clearActive;
  iel_debounce #(.TICKS(DEBOUNCE_TICKS)) uRunDebounce (
    .ref_clk(ref_clk),
    .rstSyncN(rstSyncN),
    .tick(tick),
    .level(runSync_q[1]),
    .stableQ(runLevel)
  ); // RQ20
  assign hwRunActive = runPolarityHigh ? runLevel : ~runLevel; // RQ12
  assign clearActive = faultClearPolarityHigh ? clrSync_q[1] : ~clrSync_q[1];
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      runPermitQ <= 1'b0;
    end else if (permitFromSoftware) begin
      runPermitQ <= hwRunActive & softwareStart; // RQ14
    end else begin
      runPermitQ <= hwRunActive; // RQ15
    end
  end

  // ==========================================================
  // Mode sequencing
  iel_mode_e mode_q;
  logic [TIMER_W-1:0] step_q;
  logic stepDone;
  assign stepDone = tick && (step_q == TIMER_W'(LAMP_TEST_TICKS - 1));
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      step_q <= '0;
    end else if (stepDone) begin
      step_q <= '0;
    end else if (tick) begin
      step_q <= step_q + 1'b1;
    end
  end

  // No exit from lockout: only rstn brings the mode back to boot
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      mode_q <= BOOT_RED;
    end else begin
      unique case (mode_q)
        BOOT_RED: if (stepDone) mode_q <= BOOT_YELLOW; // RQ7
        BOOT_YELLOW: if (stepDone) mode_q <= BOOT_GREEN; // RQ7
        BOOT_GREEN: if (stepDone) mode_q <= RUN_NORMAL; // RQ7
        RUN_NORMAL: if (lockoutRequest) mode_q <= LOCKOUT;
        LOCKOUT: mode_q <= LOCKOUT; // RQ9
      endcase
    end
  end

  // ==========================================================
  // Fault latches
  logic anyFault;
  logic [1:0] faultCount;
  // Set wins over clear so a fault in the clearing cycle stays
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      faultsQ <= '0;
    end else begin
      faultsQ.sensor <= faultEvents.sensor | (faultsQ.sensor & ~clearActive); // RQ17
      faultsQ.overcurrent <= faultEvents.overcurrent | ocSync_q[1]
                             | (faultsQ.overcurrent & ~clearActive); // RQ16
      faultsQ.overTemp <= faultEvents.overTemp | (faultsQ.overTemp & ~clearActive); // RQ17
    end
  end
  assign anyFault = |faultsQ;
  always_comb begin
    if (faultsQ.sensor) begin
      faultCount = FLASH_ONE; // RQ21
    end else if (faultsQ.overcurrent) begin
      faultCount = FLASH_TWO; // RQ1
    end else if (faultsQ.overTemp) begin
      faultCount = FLASH_THREE; // RQ1
    end else begin
      faultCount = FLASH_NONE; // RQ1
    end
  end

  // Synchronised pin cuts the stage directly, not through the latch
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      powerStageEnableQ <= 1'b0;
      healthyOutputQ <= 1'b0;
    end else begin
      powerStageEnableQ <= runPermitQ && mode_q == RUN_NORMAL && !anyFault
                           && !ocSync_q[1]; // RQ13 RQ16
      healthyOutputQ <= mode_q == RUN_NORMAL && !anyFault; // RQ18
    end
  end

  // ==========================================================
  // Regulation indication
  logic inBand;
  logic [1:0] regCount;
  logic faultFlash;
  logic regFlash;
  assign inBand = !tempBelowBand && !tempAboveBand;
  always_comb begin
    if (!runPermitQ) begin
      regCount = FLASH_NONE; // RQ2
    end else if (tempBelowBand) begin
      regCount = FLASH_ONE; // RQ4
    end else if (tempAboveBand) begin
      regCount = FLASH_TWO; // RQ5
    end else begin
      regCount = FLASH_NONE;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      regulationStatusQ <= 1'b0;
    end else begin
      regulationStatusQ <= runPermitQ && inBand; // RQ3
    end
  end

  iel_flash_gen uFaultFlash (
    .ref_clk(ref_clk),
    .rstSyncN(rstSyncN),
    .tick(tick),
    .flashCount(faultCount),
    .steadyOn(1'b0),
    .lampQ(faultFlash)
  ); // RQ19

  iel_flash_gen uRegFlash (
    .ref_clk(ref_clk),
    .rstSyncN(rstSyncN),
    .tick(tick),
    .flashCount(regCount),
    .steadyOn(runPermitQ && inBand),
    .lampQ(regFlash)
  ); // RQ3 RQ19

  // ==========================================================
  // Serial activity stretchers
  logic [TIMER_W-1:0] rxTimer_q;
  logic [TIMER_W-1:0] txTimer_q;
  // A burst restarts only after the dark half so the lamp flickers
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rxTimer_q <= '0;
      txTimer_q <= '0;
    end else begin
      if (rxActivity && rxTimer_q == '0) begin
        rxTimer_q <= TIMER_W'(2 * ACTIVITY_TICKS); // RQ10
      end else if (tick && rxTimer_q != '0) begin
        rxTimer_q <= rxTimer_q - 1'b1;
      end
      if (txActivity && txTimer_q == '0) begin
        txTimer_q <= TIMER_W'(2 * ACTIVITY_TICKS); // RQ10
      end else if (tick && txTimer_q != '0) begin
        txTimer_q <= txTimer_q - 1'b1;
      end
    end
  end

  // ==========================================================
  // Lamp drive
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lampsQ <= '0;
    end else begin
      unique case (mode_q)
        BOOT_RED: lampsQ <= '{fault: 1'b1, default: 1'b0}; // RQ7
        BOOT_YELLOW: lampsQ <= '{regulation: 1'b1, default: 1'b0}; // RQ7
        BOOT_GREEN: lampsQ <= '{heartbeat: 1'b1, default: 1'b0}; // RQ7
        LOCKOUT: begin
          lampsQ.fault <= blink_q; // RQ8
          lampsQ.regulation <= blink_q; // RQ8
          lampsQ.heartbeat <= blink_q; // RQ8
          lampsQ.rx <= 1'b0;
          lampsQ.tx <= 1'b0;
        end
        RUN_NORMAL: begin
          lampsQ.fault <= faultFlash; // RQ1
          lampsQ.regulation <= regFlash; // RQ2
          lampsQ.heartbeat <= blink_q; // RQ6
          if (pcSession) begin
            lampsQ.rx <= blink_q; // RQ11
            lampsQ.tx <= blink_q; // RQ11
          end else begin
            lampsQ.rx <= rxTimer_q > TIMER_W'(ACTIVITY_TICKS); // RQ10
            lampsQ.tx <= txTimer_q > TIMER_W'(ACTIVITY_TICKS); // RQ10
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstSyncN);
  property p_faultDark;
    (mode_q == RUN_NORMAL && faultCount == FLASH_NONE)[*3] |-> !lampsQ.fault;
  endproperty
  a_faultDark: assert property (p_faultDark) else $error("fault lamp lit without fault"); // RQ1
  property p_sensorFirst;
    faultsQ.sensor |-> faultCount == FLASH_ONE;
  endproperty
  a_sensorFirst: assert property (p_sensorFirst) else $error("sensor fault not first"); // RQ21
  property p_regOff;
    (mode_q == RUN_NORMAL && !runPermitQ)[*3] |-> !lampsQ.regulation;
  endproperty
  a_regOff: assert property (p_regOff) else $error("regulation lamp on while disabled"); // RQ2
  property p_regSteady;
    (mode_q == RUN_NORMAL && runPermitQ && inBand)[*3] |-> lampsQ.regulation;
  endproperty
  a_regSteady: assert property (p_regSteady) else $error("regulation lamp not steady"); // RQ3
  property p_bootOrder;
    mode_q == BOOT_YELLOW |-> $past(mode_q) inside {BOOT_RED, BOOT_YELLOW};
  endproperty
  a_bootOrder: assert property (p_bootOrder) else $error("boot lamp order broken"); // RQ7
  property p_lockStays;
    mode_q == LOCKOUT |=> mode_q == LOCKOUT;
  endproperty
  a_lockStays: assert property (p_lockStays) else $error("lockout was left"); // RQ9
  property p_lockUnison;
    (mode_q == LOCKOUT)[*2] |-> lampsQ.fault == lampsQ.regulation
                               && lampsQ.regulation == lampsQ.heartbeat;
  endproperty
  a_lockUnison: assert property (p_lockUnison) else $error("lockout lamps not in unison"); // RQ8
  property p_swPermit;
    permitFromSoftware |=> runPermitQ == ($past(hwRunActive) && $past(softwareStart));
  endproperty
  a_swPermit: assert property (p_swPermit) else $error("software permit not AND"); // RQ14
  property p_hwPermit;
    !permitFromSoftware |=> runPermitQ == $past(hwRunActive);
  endproperty
  a_hwPermit: assert property (p_hwPermit) else $error("hardware permit wrong"); // RQ15
  property p_ocCut;
    ocSync_q[1] |=> !powerStageEnableQ && faultsQ.overcurrent;
  endproperty
  a_ocCut: assert property (p_ocCut) else $error("overcurrent did not cut stage"); // RQ16
  property p_healthy;
    ##1 healthyOutputQ == ($past(mode_q) == RUN_NORMAL && !$past(anyFault));
  endproperty
  a_healthy: assert property (p_healthy) else $error("healthy output wrong"); // RQ18
  property p_clear;
    clearActive && !ocSync_q[1] && faultEvents == '0 |=> faultsQ == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("fault clear ignored"); // RQ17
  c_lockout: cover property (mode_q == RUN_NORMAL ##1 mode_q == LOCKOUT);
  c_bootDone: cover property (mode_q == BOOT_GREEN ##1 mode_q == RUN_NORMAL);
  c_twoFlash: cover property (faultCount == FLASH_TWO && lampsQ.fault);
  c_permit: cover property (permitFromSoftware && runPermitQ);
endmodule // iel_indicator_enable

/* iel_indicator_enable_tb.sv */
`timescale 1ns/1ns
module iel_indicator_enable_tb import iel_pkg::*; ();
  // ==========================================================
  // Signals
  localparam int TK = 4;
  localparam int DARK_MIN = FLASH_OFF_TICKS * TK * 3 / 2;
  localparam int TIMEOUT = 95000;
  logic ref_clk, rstn;
  logic runPolarityHigh, permitFromSoftware, softwareStart, faultClearPolarityHigh;
  logic tempBelowBand, tempAboveBand, lockoutRequest, rxActivity, txActivity, pcSession;
  logic runDriveEn, runDriveLevel, clearDriveEn, clearDriveLevel, shortLevel;
  logic runRequestPin, faultClearInputPin, overcurrentPin;
  logic runPermitQ, powerStageEnableQ, regulationStatusQ, healthyOutputQ;
  iel_fault_s faultEvents, faultsQ;
  iel_lamp_s lampsQ;
  int miscompares, totalChecks, cycleCount, n;

  iel_operator_model u_ops (.runDriveEn(runDriveEn), .runDriveLevel(runDriveLevel),
    .clearDriveEn(clearDriveEn), .clearDriveLevel(clearDriveLevel), .shortLevel(shortLevel),
    .runRequestPin(runRequestPin), .faultClearInputPin(faultClearInputPin),
    .overcurrentPin(overcurrentPin));

  iel_indicator_enable #(.TICK_CLKS(TK)) dut (.ref_clk(ref_clk), .rstn(rstn),
    .runRequestPin(runRequestPin), .runPolarityHigh(runPolarityHigh),
    .permitFromSoftware(permitFromSoftware), .softwareStart(softwareStart),
    .faultClearInputPin(faultClearInputPin), .faultClearPolarityHigh(faultClearPolarityHigh),
    .overcurrentPin(overcurrentPin), .faultEvents(faultEvents), .tempBelowBand(tempBelowBand),
    .tempAboveBand(tempAboveBand), .lockoutRequest(lockoutRequest), .rxActivity(rxActivity),
    .txActivity(txActivity), .pcSession(pcSession), .lampsQ(lampsQ), .faultsQ(faultsQ),
    .runPermitQ(runPermitQ), .powerStageEnableQ(powerStageEnableQ),
    .regulationStatusQ(regulationStatusQ), .healthyOutputQ(healthyOutputQ));

  // ==========================================================
  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycleCount++;
    if (cycleCount == TIMEOUT) begin
      miscompares++;
      $display("[FAIL] %0t run hung", $time);
      finish_test();
    end
  end

  // ==========================================================
  // Helpers
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Counts the flashes of one whole group, framed by dark pauses
  task automatic flash_group(input int idx, output int cnt);
    int dark;
    int guard;
    logic prev;
    cnt = 0;
    dark = 0;
    guard = 0;
    prev = 1'b0;
    while (dark < DARK_MIN && guard < 20000) begin
      cyc(1);
      guard++;
      dark = (lampsQ[idx] === 1'b1) ? 0 : dark + 1;
    end
    dark = 0;
    while ((cnt == 0 || dark < DARK_MIN) && guard < 40000) begin
      cyc(1);
      guard++;
      if (lampsQ[idx] === 1'b1 && prev !== 1'b1) cnt++;
      prev = lampsQ[idx];
      dark = (lampsQ[idx] === 1'b1) ? 0 : dark + 1;
    end
  endtask

  // Periodic blink: one or two rises in a little over one period
  task automatic check_blink(input int idx, input string what);
    int cnt;
    logic prev;
    cnt = 0;
    prev = lampsQ[idx];
    repeat (HEARTBEAT_TICKS * TK * 2 + 500) begin
      cyc(1);
      if (lampsQ[idx] === 1'b1 && prev !== 1'b1) cnt++;
      prev = lampsQ[idx];
    end
    check({7'h0, cnt >= 1 && cnt <= 2}, 8'h1, what);
  endtask

  task automatic clear_faults();
    clearDriveEn = 1'b1;
    cyc(4);
    clearDriveEn = 1'b0;
    cyc(4);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    rstn = 1'b0;
    {runPolarityHigh, permitFromSoftware, softwareStart, faultClearPolarityHigh} = 4'h0;
    {tempBelowBand, tempAboveBand, lockoutRequest, rxActivity, txActivity, pcSession} = 6'h0;
    {runDriveEn, runDriveLevel, clearDriveEn, clearDriveLevel, shortLevel} = 5'h0;
    faultEvents = 3'h0;
    miscompares = 0;
    totalChecks = 0;
    cycleCount = 0;
    cyc(2);
    check({3'h0, lampsQ}, 8'h00, "lamps in reset");
    rstn = 1'b1;
    cyc(LAMP_TEST_TICKS * TK / 2);
    check({3'h0, lampsQ}, 8'h10, "boot red");
    check({7'h0, healthyOutputQ}, 8'h0, "healthy in boot");
    // Boot ignores a lockout request
    lockoutRequest = 1'b1;
    cyc(1);
    lockoutRequest = 1'b0;
    cyc(LAMP_TEST_TICKS * TK - 1);
    check({3'h0, lampsQ}, 8'h08, "boot yellow");
    cyc(LAMP_TEST_TICKS * TK);
    check({3'h0, lampsQ}, 8'h04, "boot green");
    cyc(LAMP_TEST_TICKS * TK);
    check({7'h0, healthyOutputQ}, 8'h1, "healthy in run");
    check({7'h0, lampsQ.fault}, 8'h0, "fault lamp dark");
    check_blink(2, "heartbeat");
    $display("Boot test done");

    // Software permit source, active-low run pin
    permitFromSoftware = 1'b1;
    runDriveEn = 1'b1;
    cyc(DEBOUNCE_TICKS * TK + 20);
    check({7'h0, runPermitQ}, 8'h0, "hw only, sw source");
    softwareStart = 1'b1;
    cyc(3);
    check({6'h0, runPermitQ, powerStageEnableQ}, 8'h3, "hw and sw");
    permitFromSoftware = 1'b0;
    softwareStart = 1'b0;
    cyc(3);
    check({7'h0, runPermitQ}, 8'h1, "hw source ignores sw");
    runDriveEn = 1'b0;
    cyc(DEBOUNCE_TICKS * TK + 20);
    check({7'h0, runPermitQ}, 8'h0, "open pin");
    runDriveEn = 1'b1;
    cyc(DEBOUNCE_TICKS * TK / 2);
    runDriveEn = 1'b0;
    cyc(DEBOUNCE_TICKS * TK + 20);
    check({7'h0, runPermitQ}, 8'h0, "short glitch");
    runPolarityHigh = 1'b1;
    cyc(DEBOUNCE_TICKS * TK + 20);
    check({7'h0, runPermitQ}, 8'h1, "active high pin");
    runPolarityHigh = 1'b0;
    runDriveEn = 1'b1;
    cyc(DEBOUNCE_TICKS * TK + 20);
    $display("Permit test done");

    // Regulation lamp
    check({6'h0, lampsQ.regulation, regulationStatusQ}, 8'h3, "in band");
    tempBelowBand = 1'b1;
    flash_group(3, n);
    check(n[7:0], 8'h1, "too cold");
    tempBelowBand = 1'b0;
    tempAboveBand = 1'b1;
    flash_group(3, n);
    check(n[7:0], 8'h2, "too hot");
    runDriveEn = 1'b0;
    cyc(DEBOUNCE_TICKS * TK + 20);
    check({6'h0, lampsQ.regulation, regulationStatusQ}, 8'h0, "disabled");
    tempAboveBand = 1'b0;
    runDriveEn = 1'b1;
    cyc(DEBOUNCE_TICKS * TK + 20);
    $display("Regulation test done");

    // Faults
    faultEvents = 3'h5;
    cyc(1);
    faultEvents = 3'h0;
    cyc(2);
    check({5'h0, faultsQ}, 8'h05, "faults latched");
    check({7'h0, healthyOutputQ}, 8'h0, "healthy with fault");
    flash_group(4, n);
    check(n[7:0], 8'h1, "sensor first");
    clear_faults();
    check({5'h0, faultsQ}, 8'h00, "cleared");
    faultEvents = 3'h1;
    cyc(1);
    faultEvents = 3'h0;
    flash_group(4, n);
    check(n[7:0], 8'h3, "overtemp");
    clear_faults();
    cyc(4);
    check({7'h0, powerStageEnableQ}, 8'h1, "stage on");
    shortLevel = 1'b1;
    cyc(4);
    check({6'h0, faultsQ.overcurrent, powerStageEnableQ}, 8'h2, "short cut");
    shortLevel = 1'b0;
    flash_group(4, n);
    check(n[7:0], 8'h2, "overcurrent");
    clear_faults();
    check({7'h0, healthyOutputQ}, 8'h1, "healthy again");
    $display("Fault test done");

    // Serial activity
    rxActivity = 1'b1;
    cyc(1);
    rxActivity = 1'b0;
    cyc(3);
    check({6'h0, lampsQ.rx, lampsQ.tx}, 8'h2, "rx");
    cyc(ACTIVITY_TICKS * TK * 2 + 10);
    txActivity = 1'b1;
    cyc(1);
    txActivity = 1'b0;
    cyc(3);
    check({6'h0, lampsQ.rx, lampsQ.tx}, 8'h1, "tx");
    pcSession = 1'b1;
    check_blink(1, "session rx");
    check_blink(0, "session tx");
    pcSession = 1'b0;
    $display("Activity test done");

    // Lockout
    lockoutRequest = 1'b1;
    cyc(1);
    lockoutRequest = 1'b0;
    cyc(10);
    repeat (20) begin
      cyc(200);
      check({7'h0, lampsQ[4:2] === 3'h0 || lampsQ[4:2] === 3'h7}, 8'h1, "unison");
    end
    check_blink(4, "lockout blink");
    softwareStart = 1'b1;
    clear_faults();
    lockoutRequest = 1'b1;
    cyc(1);
    lockoutRequest = 1'b0;
    check_blink(4, "still locked");
    check({7'h0, healthyOutputQ}, 8'h0, "healthy in lockout");
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    cyc(LAMP_TEST_TICKS * TK / 2);
    check({3'h0, lampsQ}, 8'h10, "reboot");
    $display("Lockout test done");
    finish_test();
  end
endmodule // iel_indicator_enable_tb

/* iel_operator_model.sv */
`timescale 1ns/1ns
module iel_operator_model import iel_pkg::*; (
  input wire logic runDriveEn,
  input wire logic runDriveLevel,
  input wire logic clearDriveEn,
  input wire logic clearDriveLevel,
  input wire logic shortLevel,
  output logic runRequestPin,
  output logic faultClearInputPin,
  output logic overcurrentPin
);
  // ==========================================================
  // Switch contacts and load short
  // Open contact floats to the pull-up level
  assign runRequestPin = runDriveEn ? runDriveLevel : PIN_IDLE_LEVEL;
  assign faultClearInputPin = clearDriveEn ? clearDriveLevel : PIN_IDLE_LEVEL;
  assign overcurrentPin = shortLevel;
endmodule // iel_operator_model

/* iel_pkg.sv */
package iel_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_MS = TICK_PERIOD_NS / 1000000;
  localparam int FLASH_ON_MS = 200;
  localparam int FLASH_OFF_MS = 200;
  localparam int FLASH_PAUSE_MS = 1000;
  localparam int HEARTBEAT_MS = 500;
  localparam int LAMP_TEST_MS = 500;
  localparam int DEBOUNCE_MS = 10;
  localparam int ACTIVITY_MS = 50;
  localparam int FLASH_ON_TICKS = FLASH_ON_MS / TICK_MS;
  localparam int FLASH_OFF_TICKS = FLASH_OFF_MS / TICK_MS;
  localparam int FLASH_PAUSE_TICKS = FLASH_PAUSE_MS / TICK_MS;
  localparam int HEARTBEAT_TICKS = HEARTBEAT_MS / TICK_MS;
  localparam int LAMP_TEST_TICKS = LAMP_TEST_MS / TICK_MS;
  localparam int DEBOUNCE_TICKS = DEBOUNCE_MS / TICK_MS;
  localparam int ACTIVITY_TICKS = ACTIVITY_MS / TICK_MS;
  localparam int TIMER_W = 11;

  // ==========================================================
  // Encodings and reset levels
  localparam logic [1:0] FLASH_NONE = 2'h0;
  localparam logic [1:0] FLASH_ONE = 2'h1;
  localparam logic [1:0] FLASH_TWO = 2'h2;
  localparam logic [1:0] FLASH_THREE = 2'h3;
  localparam logic PIN_IDLE_LEVEL = 1'h1;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {BOOT_RED, BOOT_YELLOW, BOOT_GREEN, RUN_NORMAL, LOCKOUT} iel_mode_e;
  typedef enum logic [1:0] {FG_IDLE, FG_ON, FG_GAP, FG_PAUSE} iel_flash_e;

  typedef struct packed {
    logic sensor;
    logic overcurrent;
    logic overTemp;
  } iel_fault_s;

  typedef struct packed {
    logic fault;
    logic regulation;
    logic heartbeat;
    logic rx;
    logic tx;
  } iel_lamp_s;

endpackage
